/* core/sidsc_core.sv */
/*
  Separate-I/O burst-of-4 DDR SRAM core: command decode, DDR capture and
  drive, byte-lane masked commit, sticky ECC-off flag, impedance stepping.
  Assumes kClk high phase is K and its falling edge stands for the K-bar
  rise; the link is synchronous to kClk, mclk is unrelated.
*/
`timescale 1ns/1ns
// Operation
// - each mask pin governs two-beat 18-bit location
// - mask low both stores; high both aborts
// - one low beat stores that byte only
// - mask 0 lanes bits 8:0, 1 bits 17:9
// - mask 2 bits 26:18, 3 bits 35:27
// - half write turns error correction off
// - cycle counter triggers impedance evaluation periodically
// - each evaluation moves drive one step, except at an end of the code range
// - read beats at n+1.5, 2, 2.5, 3
// - tail beats overlap the next command
// - both selects high deselects, output off
// - low select decodes read or write
// - read ignored after a loaded read
// - write ignored after a write
// - correction stays off once disabled
module sidsc_core
  import sidsc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              kClk,
  input  wire logic [ADDR_W-1:0] addrIn,
  input  wire logic              readSelLow,
  input  wire logic              writeSelLow,
  input  wire logic [LANES-1:0]  byteLaneMaskLow,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOutOeN,
  input  wire logic              impedanceSensePin,
  output logic [CODE_W-1:0]      driveCode,
  output logic                   eccActive
);
  function automatic logic [LANE_W-1:0] laneByte(input logic [DATA_W-1:0] w, input int l);
    return w[l*LANE_W +: LANE_W];
  endfunction

  // ---------------- link domain (kClk) ----------------
  sidsc_cmd_t                 lastCmdReg;
  sidsc_cmd_t                 lastCmdNext;
  logic                       rdGoQ;
  logic                       wrGo;
  logic                       rdS1Reg, rdS2Reg, rdS3Reg;
  logic                       wrS1Reg, wrS2Reg, wrS3Reg;
  logic [ADDR_W-1:0]          rdAddrReg;
  logic [ADDR_W-1:0]          wrAddrReg;
  logic [ADDR_W-1:0]          wrAddrHoldReg;
  logic [1:0][DATA_W-1:0]     posDataReg;
  logic [1:0][LANES-1:0]      posMaskReg;
  logic [1:0][DATA_W-1:0]     negDataReg;
  logic [1:0][LANES-1:0]      negMaskReg;
  logic [BEATS-1:0][DATA_W-1:0] rdBufReg;
  logic [DATA_W-1:0]          posQReg;
  logic [DATA_W-1:0]          negQReg;
  logic                       posOeReg;
  logic                       negOeReg;
  logic                       halfTogReg;
  sidsc_wr_t                  pushWord;
  sidsc_wr_t                  drainWord;
  logic                       qInReady;
  logic                       qRoom;
  logic                       qOutValid;
  logic                       drainGo;
  logic                       halfHit;
  logic [PAIR_W-1:0]          memArr [MEM_WORDS][HALVES][LANES];

  // low select decodes a command, read first when both are low
  // a read right after a loaded read is dropped
  // a write right after a write is dropped
  // the queue must hold this burst plus one still in flight
  assign rdGoQ       = ~readSelLow & (lastCmdReg != CMD_READ);
  assign wrGo        = ~writeSelLow & ~rdGoQ & (lastCmdReg != CMD_WRITE) & qRoom;
  assign lastCmdNext = rdGoQ ? CMD_READ : (wrGo ? CMD_WRITE : CMD_IDLE);

  // tail beats of a prior command run on while the next one loads
  always_ff @(posedge kClk or negedge resetn)
  begin
    if (!resetn)
    begin
      lastCmdReg <= CMD_IDLE;
      {rdS1Reg, rdS2Reg, rdS3Reg} <= '0;
      {wrS1Reg, wrS2Reg, wrS3Reg} <= '0;
      posOeReg   <= 1'b0;
      halfTogReg <= 1'b0;
    end
    else
    begin
      lastCmdReg <= lastCmdNext;
      {rdS1Reg, rdS2Reg, rdS3Reg} <= {rdGoQ, rdS1Reg, rdS2Reg};
      {wrS1Reg, wrS2Reg, wrS3Reg} <= {wrGo, wrS1Reg, wrS2Reg};
      // output off unless a read beat is due this half cycle
      posOeReg   <= rdS2Reg | rdS3Reg;
      // a half write flips the event toggle toward mclk
      halfTogReg <= halfTogReg ^ (wrS3Reg & halfHit);
    end
  end

  // positive-edge beats: Q1 at n+2, Q3 at n+3
  // positive-edge write beats taken at n+1 and n+2
  always_ff @(posedge kClk)
  begin
    if (rdGoQ)
      rdAddrReg <= addrIn;
    if (wrGo)
      wrAddrReg <= addrIn;
    // keep the address past n+2, where an alternating write reloads it
    if (wrS2Reg)
      wrAddrHoldReg <= wrAddrReg;
    if (wrS1Reg)
    begin
      posDataReg[0] <= dataIn;
      posMaskReg[0] <= byteLaneMaskLow;
    end
    if (wrS2Reg)
    begin
      posDataReg[1] <= dataIn;
      posMaskReg[1] <= byteLaneMaskLow;
    end
    posQReg <= rdS2Reg ? rdBufReg[1] : rdBufReg[3];
  end

  // negative-edge beats: Q0 at n+1.5, Q2 at n+2.5
  // negative-edge write beats taken at n+1.5 and n+2.5
  always_ff @(negedge kClk or negedge resetn)
  begin
    if (!resetn)
    begin
      negOeReg   <= 1'b0;
      negQReg    <= '0;
      negDataReg <= '0;
      negMaskReg <= '1;
    end
    else
    begin
      negOeReg <= rdS2Reg | rdS3Reg;
      negQReg  <= rdS2Reg ? rdBufReg[0] : rdBufReg[2];
      if (wrS2Reg)
      begin
        negDataReg[0] <= dataIn;
        negMaskReg[0] <= byteLaneMaskLow;
      end
      if (wrS3Reg)
      begin
        negDataReg[1] <= dataIn;
        negMaskReg[1] <= byteLaneMaskLow;
      end
    end
  end

  // DDR output: the register of the current clock phase drives the pins
  assign dataOut    = kClk ? posQReg : negQReg;
  assign dataOutOeN = kClk ? ~posOeReg : ~negOeReg;

  // burst assembly in beat order; pairs beats 0/1 and 2/3 per lane
  assign pushWord.addr    = wrAddrHoldReg;
  assign pushWord.data    = {negDataReg[1], posDataReg[1], negDataReg[0], posDataReg[0]};
  assign pushWord.maskLow = {negMaskReg[1], posMaskReg[1], negMaskReg[0], posMaskReg[0]};
  // mask differing inside a pair means a half write
  assign halfHit = |(pushWord.maskLow[0] ^ pushWord.maskLow[1])
                 | |(pushWord.maskLow[2] ^ pushWord.maskLow[3]);

  // the array port is busy for read fetch, so commit waits that cycle
  assign drainGo = qOutValid & ~rdS1Reg;

  sidsc_fifo #(
    .WIDTH ($bits(sidsc_wr_t)),
    .DEPTH (WQ_DEPTH)
  ) uWriteQueue (
    .clk        (kClk),
    .resetn     (resetn),
    .inValid    (wrS3Reg),
    .inReady    (qInReady),
    .inData     (pushWord),
    .roomForTwo (qRoom),
    .outValid   (qOutValid),
    .outReady   (~rdS1Reg),
    .outData    (drainWord)
  );

  // each byte of a pair is stored only where its mask is low
  // lane l covers data bits l*9+8 down to l*9
  // a full pair lands in one 18-bit word, first beat low
  always_ff @(posedge kClk)
  begin
    if (drainGo)
      for (int h = 0; h < HALVES; h++)
        for (int l = 0; l < LANES; l++)
        begin
          if (!drainWord.maskLow[2*h][l])
            memArr[drainWord.addr][h][l][LANE_W-1:0] <= laneByte(drainWord.data[2*h], l);
          if (!drainWord.maskLow[2*h+1][l])
            memArr[drainWord.addr][h][l][PAIR_W-1:LANE_W] <=
              laneByte(drainWord.data[2*h+1], l);
        end
    // fetch at n+1 so Q0 is ready for the n+1.5 edge
    if (rdS1Reg)
      for (int b = 0; b < BEATS; b++)
        for (int l = 0; l < LANES; l++)
          rdBufReg[b][l*LANE_W +: LANE_W] <=
            memArr[rdAddrReg][b/2][l][(b%2)*LANE_W +: LANE_W];
  end

  // ---------------- core domain (mclk) ----------------
  logic                halfSync1Reg, halfSync2Reg, halfSync3Reg;
  logic                senseSync1Reg, senseSync2Reg;
  logic                eccOffReg;
  logic [ZQ_CNT_W-1:0] zqCntReg;
  logic [CODE_W-1:0]   codeReg;
  logic                zqEval;
  logic                halfSeen;

  // evaluation fires when the counter wraps
  assign zqEval   = (zqCntReg == ZQ_CNT_W'(ZQ_EVAL_CYCLES - 1));
  assign halfSeen = halfSync2Reg ^ halfSync3Reg;
  assign eccActive = ~eccOffReg;
  assign driveCode = codeReg;

  // toggle and pin synchronisers; the pin is read at its second stage, the toggle at stages two and three
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      {halfSync1Reg, halfSync2Reg, halfSync3Reg} <= '0;
      {senseSync1Reg, senseSync2Reg} <= '0;
    end
    else
    begin
      {halfSync1Reg, halfSync2Reg, halfSync3Reg} <= {halfTogReg, halfSync1Reg, halfSync2Reg};
      {senseSync1Reg, senseSync2Reg} <= {impedanceSensePin, senseSync1Reg};
    end
  end

  // sticky until power goes; only reset stands in for power-up
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      eccOffReg <= 1'b0;
    else if (halfSeen)
      eccOffReg <= 1'b1;
  end

  // count, evaluate, clear and count again
  // one binary step per evaluation, saturating at the ends
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      zqCntReg <= '0;
      codeReg  <= CODE_RESET;
    end
    else
    begin
      zqCntReg <= zqEval ? '0 : ZQ_CNT_W'(zqCntReg + 1'b1);
      if (zqEval && senseSync2Reg && codeReg != CODE_MAX)
        codeReg <= CODE_W'(codeReg + 1'b1);
      else if (zqEval && !senseSync2Reg && codeReg != CODE_MIN)
        codeReg <= CODE_W'(codeReg - 1'b1);
    end
  end

  // ---------------- checks ----------------
  chk_read_after_read: assert property (
    @(posedge kClk) disable iff (!resetn)
    rdGoQ |=> !rdGoQ)
    else $error("read taken right after a read");

  chk_write_after_write: assert property (
    @(posedge kClk) disable iff (!resetn)
    wrGo |=> !wrGo)
    else $error("write taken right after a write");

  chk_read_beat_slots: assert property (
    @(posedge kClk) disable iff (!resetn)
    rdGoQ |-> ##2 negOeReg ##1 (posOeReg && negOeReg) ##1 posOeReg)
    else $error("read beats not driven at n+1.5 to n+3");

  chk_deselect_off: assert property (
    @(posedge kClk) disable iff (!resetn)
    (!rdGoQ && !$past(rdGoQ)) |-> ##3 !posOeReg)
    else $error("output driven with no read due");

  chk_select_decode: assert property (
    @(posedge kClk) disable iff (!resetn)
    (readSelLow && writeSelLow) |-> (!rdGoQ && !wrGo))
    else $error("command decoded while deselected");

  chk_write_commit: assert property (
    @(posedge kClk) disable iff (!resetn)
    wrGo |-> ##3 (wrS3Reg && qInReady))
    else $error("write burst not queued at n+3");

  chk_ecc_off_set: assert property (
    @(posedge mclk) disable iff (!resetn)
    halfSeen |=> !eccActive)
    else $error("half write left correction on");

  chk_ecc_stays_off: assert property (
    @(posedge mclk) disable iff (!resetn)
    eccOffReg |=> eccOffReg)
    else $error("correction came back on");

  chk_zq_period: assert property (
    @(posedge mclk) disable iff (!resetn)
    zqEval |=> (zqCntReg == '0) ##1 (zqCntReg == ZQ_CNT_W'(1)))
    else $error("impedance counter did not restart");

  chk_zq_one_step: assert property (
    @(posedge mclk) disable iff (!resetn)
    (codeReg != $past(codeReg)) |->
      ((codeReg == CODE_W'($past(codeReg) + 1'b1)) ||
       (codeReg == CODE_W'($past(codeReg) - 1'b1))) && $past(zqEval))
    else $error("drive code moved more than one step");

  cov_read:      cover property (@(posedge kClk) disable iff (!resetn) rdGoQ);
  cov_write:     cover property (@(posedge kClk) disable iff (!resetn) wrGo);
  cov_alternate: cover property (@(posedge kClk) disable iff (!resetn) rdGoQ ##1 wrGo ##1 rdGoQ);
  cov_half:      cover property (@(posedge kClk) disable iff (!resetn) wrS3Reg && halfHit);

endmodule

/* core/sidsc_fifo.sv */
/*
  Single-clock FIFO with valid/ready on both sides and a room flag.
  Assumes the writer honours inReady/roomForTwo and the reader may stall.
*/
`timescale 1ns/1ns
module sidsc_fifo
  import sidsc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  roomForTwo,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wrPtrReg;
  logic [PW-1:0]    rdPtrReg;
  logic [PW:0]      countReg;
  logic             pushGo;
  logic             popGo;

  // flags from the occupancy count
  assign inReady    = (countReg != (PW+1)'(DEPTH));
  assign roomForTwo = (countReg < (PW+1)'(DEPTH - 1));
  assign outValid   = (countReg != '0);
  assign outData    = store[rdPtrReg];
  assign pushGo     = inValid & inReady;
  assign popGo      = outValid & outReady;

  // pointers and count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end
    else
    begin
      if (pushGo)
        wrPtrReg <= PW'(wrPtrReg + 1'b1);
      if (popGo)
        rdPtrReg <= PW'(rdPtrReg + 1'b1);
      countReg <= (PW+1)'(countReg + pushGo - popGo);
    end
  end

  // storage has no reset; words are only read once counted in
  always_ff @(posedge clk)
  begin
    if (pushGo)
      store[wrPtrReg] <= inData;
  end

endmodule

/* core/sidsc_pkg.sv */
/*
  Shared constants and types for the separate-I/O burst-of-4 DDR SRAM core:
  lane layout, beat count, model depth, impedance calibration figures.
  Assumes every core file imports the whole package.
*/
package sidsc_pkg;

  // data lanes: four 9-bit bytes, paired into 18-bit stored words
  localparam int LANE_W    = 9;
  localparam int LANES     = 4;
  localparam int DATA_W    = LANE_W * LANES;
  localparam int PAIR_W    = 2 * LANE_W;
  localparam int BEATS     = 4;
  localparam int HALVES    = BEATS / 2;

  // model depth of the array, far below the real part to keep simulation light
  localparam int ADDR_W    = 8;
  localparam int MEM_WORDS = 1 << ADDR_W;

  // write queue between capture and array commit
  localparam int WQ_DEPTH  = 32;

  // impedance recalibration: one evaluation every ZQ_EVAL_CYCLES mclk cycles
  localparam int           ZQ_EVAL_CYCLES = 1024;
  localparam int           ZQ_CNT_W       = 10;
  localparam int           CODE_W         = 5;
  localparam logic [4:0]   CODE_RESET     = 5'h10;
  localparam logic [4:0]   CODE_MAX       = 5'h1F;
  localparam logic [4:0]   CODE_MIN       = 5'h00;

  // command last loaded at a positive link edge
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_READ,
    CMD_WRITE
  } sidsc_cmd_t;

  // one complete four-beat write, as queued for commit
  typedef struct packed {
    logic [ADDR_W-1:0]              addr;
    logic [BEATS-1:0][DATA_W-1:0]   data;
    logic [BEATS-1:0][LANES-1:0]    maskLow;
  } sidsc_wr_t;

endpackage

/* tb/sep_io_ddr_sram_cmd_bytemask_test.sv */
/*
  Self-checking bench for the SRAM core: reset values, full, aborted,
  repeated and half writes with read-back, impedance stepping.
  Assumes the controller model drives every link pin.
*/
`timescale 1ns/1ns
module sep_io_ddr_sram_cmd_bytemask_test
  import sidsc_pkg::*;
;
  typedef logic [BEATS-1:0][DATA_W-1:0] sidsc_beats_t;
  typedef logic [BEATS-1:0][LANES-1:0]  sidsc_masks_t;
  logic              mclk;
  logic              kClk;
  logic              resetn;
  logic              impedanceSensePin;
  logic [ADDR_W-1:0] addrIn;
  logic              readSelLow;
  logic              writeSelLow;
  logic [LANES-1:0]  byteLaneMaskLow;
  logic [DATA_W-1:0] dataIn;
  logic [DATA_W-1:0] dataOut;
  logic              dataOutOeN;
  logic [CODE_W-1:0] driveCode;
  logic [CODE_W-1:0] codePrev = CODE_RESET;
  logic              eccActive;
  int                badCount = 0;
  int                totalChecks = 0;
  sidsc_beats_t      shadow [MEM_WORDS];

  sidsc_core uut (.mclk(mclk), .resetn(resetn), .kClk(kClk), .addrIn(addrIn),
    .readSelLow(readSelLow), .writeSelLow(writeSelLow), .byteLaneMaskLow(byteLaneMaskLow),
    .dataIn(dataIn), .dataOut(dataOut), .dataOutOeN(dataOutOeN),
    .impedanceSensePin(impedanceSensePin), .driveCode(driveCode), .eccActive(eccActive));

  sidsc_ctrl_model ctl (.kClk(kClk), .dataOut(dataOut), .dataOutOeN(dataOutOeN),
    .addrIn(addrIn), .readSelLow(readSelLow), .writeSelLow(writeSelLow),
    .byteLaneMaskLow(byteLaneMaskLow), .dataIn(dataIn));

  // core clock, and a link clock offset so no edges coincide
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    kClk = 1'b0;
    #3;
    forever #32 kClk = ~kClk;
  end

  task automatic completeRun();
    $display("checks=%0d mismatches=%0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      badCount++;
    end
  endtask

  // distinct byte per beat and lane, so a swapped lane or beat shows
  function automatic sidsc_beats_t pat(input logic [7:0] s);
    for (int b = 0; b < BEATS; b++)
      for (int l = 0; l < LANES; l++)
        pat[b][l*LANE_W +: LANE_W] = {1'b1, s} ^ LANE_W'(b * 32 + l * 5);
  endfunction

  // a high mask bit keeps the old byte of that lane and beat
  function automatic sidsc_beats_t merge(input sidsc_beats_t o, input sidsc_beats_t n,
                                         input sidsc_masks_t m);
    merge = n;
    for (int b = 0; b < BEATS; b++)
      for (int l = 0; l < LANES; l++)
        if (m[b][l])
          merge[b][l*LANE_W +: LANE_W] = o[b][l*LANE_W +: LANE_W];
  endfunction

  task automatic idle(input int n);
    repeat (n) ctl.send_cmd(1'b1, 1'b1, '0);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input sidsc_beats_t d, input sidsc_masks_t m);
    ctl.send_cmd(1'b1, 1'b0, a);
    shadow[a] = merge(shadow[a], d, m);
    fork
      ctl.wr_data(d, m);
    join_none
  endtask

  // launch a read; its beats are judged while later commands go on
  task automatic rd(input logic [ADDR_W-1:0] a);
    sidsc_beats_t     exp;
    sidsc_beats_t     q;
    logic [BEATS-1:0] oe;
    exp = shadow[a];
    ctl.send_cmd(1'b0, 1'b1, a);
    fork
      begin
        ctl.rd_capture(q, oe);
        for (int b = 0; b < BEATS; b++)
        begin
          check(q[b], exp[b]);
          check(DATA_W'(oe[b]), '0);
        end
      end
    join_none
  endtask

  task automatic full_alternate();
    check(DATA_W'(dataOutOeN), DATA_W'(1'b1));
    check(DATA_W'(eccActive), DATA_W'(1'b1));
    wr(8'h05, pat(8'h05), '0);
    idle(5);
    wr(8'h06, pat(8'h06), '0);
    rd(8'h05);
    idle(5);
    rd(8'h06);
    wr(8'h07, pat(8'h07), '0);
    idle(5);
    rd(8'h07);
    idle(5);
  endtask

  task automatic abort_pairs();
    wr(8'h05, pat(8'h15), {4'h8, 4'h8, 4'h2, 4'h2});
    idle(5);
    rd(8'h05);
    idle(5);
    check(DATA_W'(eccActive), DATA_W'(1'b1));
  endtask

  task automatic repeat_ignored();
    wr(8'h08, pat(8'h28), '0);
    idle(5);
    wr(8'h08, pat(8'h08), {4'hF, 4'hF, 4'h0, 4'h0});
    ctl.send_cmd(1'b1, 1'b0, 8'h08);
    idle(5);
    rd(8'h08);
    ctl.send_cmd(1'b0, 1'b1, 8'h08);
    fork
      idle(4);
      begin
        repeat (3) @(posedge kClk);
        @(negedge kClk);
        #16;
        check(DATA_W'(dataOutOeN), DATA_W'(1'b1));
      end
    join
  endtask

  task automatic half_write();
    wr(8'h09, pat(8'h09), '0);
    idle(5);
    wr(8'h09, pat(8'h19), {4'h0, 4'h0, 4'h2, 4'h0});
    idle(6);
    check(DATA_W'(eccActive), DATA_W'(1'b0));
    rd(8'h09);
    idle(5);
    wr(8'h0A, pat(8'h0A), '0);
    idle(6);
    check(DATA_W'(eccActive), DATA_W'(1'b0));
  endtask

  task automatic impedance_steps();
    logic [CODE_W-1:0] c0;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge mclk);
      impedanceSensePin <= (s == 0);
      repeat (100) @(posedge mclk);
      #1;
      c0 = driveCode;
      repeat (ZQ_EVAL_CYCLES) @(posedge mclk);
      #1;
      check(DATA_W'(driveCode), DATA_W'((s == 0) ? 5'(c0 + 5'h01) : 5'(c0 - 5'h01)));
    end
  endtask

  // a changed code may differ from the last one by a single step only
  always @(posedge mclk)
  begin
    if (resetn === 1'b1 && driveCode !== codePrev)
      check(DATA_W'(driveCode == 5'(codePrev + 5'h01) || driveCode == 5'(codePrev - 5'h01)),
            DATA_W'(1'b1));
    codePrev <= driveCode;
  end

  // reset spans several link cycles so both domains see it
  initial
  begin
    resetn            = 1'b0;
    impedanceSensePin = 1'b1;
    repeat (24) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge kClk);
    check(DATA_W'(driveCode), DATA_W'(CODE_RESET));
    full_alternate();
    abort_pairs();
    repeat_ignored();
    half_write();
    impedance_steps();
    completeRun();
  end

  // the run needs about 24 us; a hang is cut at 200 us
  initial
  begin
    #200000;
    badCount++;
    completeRun();
  end
endmodule

/* tb/sidsc_ctrl_model.sv */
/*
  Memory-controller model for the link pins of the SRAM core.
  Assumes the bench makes kClk and calls these tasks in kClk-rise order.
*/
`timescale 1ns/1ns
module sidsc_ctrl_model
  import sidsc_pkg::*;
(
  input  wire logic              kClk,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic              dataOutOeN,
  output logic [ADDR_W-1:0]      addrIn,
  output logic                   readSelLow,
  output logic                   writeSelLow,
  output logic [LANES-1:0]       byteLaneMaskLow,
  output logic [DATA_W-1:0]      dataIn
);
  // idle levels at time zero
  initial
  begin
    addrIn          = '0;
    readSelLow      = 1'b1;
    writeSelLow     = 1'b1;
    byteLaneMaskLow = '1;
    dataIn          = '0;
  end

  // address moves just after a rise
  task automatic send_cmd(input logic rdL, input logic wrL, input logic [ADDR_W-1:0] a);
    @(posedge kClk);
    readSelLow  <= rdL;
    writeSelLow <= wrL;
    addrIn      <= (rdL & wrL) ? ~addrIn : a;
  endtask

  // four beats, each set one half-cycle ahead
  task automatic wr_data(input logic [BEATS-1:0][DATA_W-1:0] d,
                         input logic [BEATS-1:0][LANES-1:0] m);
    @(posedge kClk);
    for (int b = 0; b < BEATS; b++)
    begin
      if (b[0])
        @(posedge kClk);
      else
        @(negedge kClk);
      dataIn          <= d[b];
      byteLaneMaskLow <= m[b];
    end
    // released lines show the inverse so stale beats never match
    @(negedge kClk);
    dataIn          <= ~d[BEATS-1];
    byteLaneMaskLow <= ~m[BEATS-1];
  endtask

  // sample each read beat mid-phase, once the output mux has settled
  task automatic rd_capture(output logic [BEATS-1:0][DATA_W-1:0] q,
                            output logic [BEATS-1:0] oe);
    @(posedge kClk);
    @(negedge kClk);
    for (int b = 0; b < BEATS; b++)
    begin
      if (b[0])
        @(posedge kClk);
      else
        @(negedge kClk);
      #16;
      q[b]  = dataOut;
      oe[b] = dataOutOeN;
    end
  endtask
endmodule
